// file: core/itw_consts.svh
// Purpose: Offsets, field positions, reset values and counts
// Assumes: Included by bare name
// Notes:   Definitions only
`ifndef ITW_CONSTS_SVH
`define ITW_CONSTS_SVH
// ==========================================
// Sizes
`define ITW_NUM_CTRL     4
`define ITW_NUM_CPU      4
`define ITW_NUM_SETS     5'h02
`define ITW_NUM_WD       5'h04
// ==========================================
// Word offsets inside one controller window
`define ITW_OFF_WDCTL    12'h01C
`define ITW_OFF_TS_BASE  12'h100
`define ITW_OFF_TS_END   12'h11C
`define ITW_OFF_BOOT     12'h200
`define ITW_OFF_BOOT_END 12'h20C
`define ITW_TS_CNT       2'h0
`define ITW_TS_CTL       2'h1
`define ITW_TS_AST       2'h2
`define ITW_TS_ACK       2'h3
// ==========================================
// Field positions
`define ITW_TSC_COUNT    31:27
`define ITW_TSC_AFLAG    26
`define ITW_TSC_KFLAG    25
`define ITW_TSC_KEEP     5
`define ITW_TSC_SEL      4:0
`define ITW_WDC_COUNT    31:27
`define ITW_WDC_SEL      19:16
`define ITW_WDC_EN       3:0
// ==========================================
// Reset values
`define ITW_BOOT_RST     32'hC0000000
`endif

// file: core/itw_pkg.sv
// Purpose: Shared types of the stamp logic
// Assumes: Nothing beyond the constants header
// Notes:   Types only
package itw_pkg;
  // ==========================================
  // Acknowledge from one processor
  typedef struct packed {
    logic       valid;
    logic [4:0] line;
  } itw_ack_t;
endpackage

// file: core/itw_stamp_set.sv
// Purpose: One interrupt timestamp set
// Assumes: Lines and acks are on core_clk_i
// Notes:   Flags are write-one-to-clear, set wins
`timescale 1ns/1ps
`include "itw_consts.svh"
module itw_stamp_set #(
  parameter logic [1:0] CTRL_ID = 2'h0
) (
  input  wire logic                       core_clk_i,
  input  wire logic                       reset_i,
  input  wire logic                       ctl_wr_i,
  input  wire logic [31:0]                wdata_i,
  input  wire logic [31:0]                irq_lines_i,
  input  wire logic [31:0]                count_i,
  input  wire itw_pkg::itw_ack_t [3:0]    ack_i,
  input  wire logic [3:0][1:0]            owner_i,
  output logic      [31:0]                ctl_rd_o,
  output logic      [31:0]                assert_rd_o,
  output logic      [31:0]                ack_rd_o,
  output logic                            active_o
);
  logic [4:0]  capture_line_select_q;
  logic        keep_first_capture_q;
  logic        assert_captured_flag_q;
  logic        ack_captured_flag_q;
  logic [31:0] assert_stamp_q;
  logic [31:0] ack_stamp_q;
  logic        assert_hit;
  logic        ack_hit;
  logic        take_assert;
  logic        take_ack;

  // ==========================================
  // Trigger detection
  assign active_o   = (capture_line_select_q != 5'h00);
  assign assert_hit = active_o && irq_lines_i[capture_line_select_q];
  always_comb begin
    ack_hit = 1'b0;
    for (int c = 0; c < `ITW_NUM_CPU; c++) begin
      if (ack_i[c].valid && owner_i[c] == CTRL_ID && ack_i[c].line == capture_line_select_q) begin
        ack_hit = active_o;
      end
    end
  end
  assign take_assert = assert_hit && !(keep_first_capture_q && assert_captured_flag_q);
  assign take_ack    = ack_hit && !(keep_first_capture_q && ack_captured_flag_q);

  // ==========================================
  // Control fields
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      capture_line_select_q <= 5'h00;
      keep_first_capture_q  <= 1'b0;
    end else if (ctl_wr_i) begin
      capture_line_select_q <= wdata_i[`ITW_TSC_SEL];
      keep_first_capture_q  <= wdata_i[`ITW_TSC_KEEP];
    end
  end

  // Assertion flag, set beats clear
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      assert_captured_flag_q <= 1'b0;
    end else if (take_assert) begin
      assert_captured_flag_q <= 1'b1;
    end else if (ctl_wr_i && wdata_i[`ITW_TSC_AFLAG]) begin
      assert_captured_flag_q <= 1'b0;
    end
  end

  // Acknowledge flag, ack beats refresh and clear
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      ack_captured_flag_q <= 1'b0;
    end else if (take_ack) begin
      ack_captured_flag_q <= 1'b1;
    end else if (take_assert && !keep_first_capture_q) begin
      ack_captured_flag_q <= 1'b0;
    end else if (ctl_wr_i && wdata_i[`ITW_TSC_KFLAG]) begin
      ack_captured_flag_q <= 1'b0;
    end
  end

  // Stamp registers
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      assert_stamp_q <= 32'h00000000;
      ack_stamp_q    <= 32'h00000000;
    end else begin
      if (take_assert) begin
        assert_stamp_q <= count_i;
      end
      if (take_ack) begin
        ack_stamp_q <= count_i;
      end
    end
  end

  // ==========================================
  // Readback
  always_comb begin
    ctl_rd_o                 = 32'h00000000;
    ctl_rd_o[`ITW_TSC_COUNT] = `ITW_NUM_SETS;
    ctl_rd_o[`ITW_TSC_AFLAG] = assert_captured_flag_q;
    ctl_rd_o[`ITW_TSC_KFLAG] = ack_captured_flag_q;
    ctl_rd_o[`ITW_TSC_KEEP]  = keep_first_capture_q;
    ctl_rd_o[`ITW_TSC_SEL]   = capture_line_select_q;
  end
  assign assert_rd_o = assert_stamp_q;
  assign ack_rd_o    = ack_stamp_q;
endmodule

// file: core/itw_top.sv
// Purpose: Timestamp, watchdog and boot address extension of the
//          multiprocessor interrupt controller
// Assumes: APB slave on core_clk_i, 25 MHz; interrupt lines,
//          acknowledges and watchdog ticks come from logic on
//          the same clock
// Notes:   Four internal controllers at 4 KiB strides,
//          two stamp sets each, read data registered in setup
`timescale 1ns/1ps
`include "itw_consts.svh"

module itw_top (
  input  wire logic                       core_clk_i,
  input  wire logic                       reset_i,
  // APB slave
  input  wire logic                       apb_psel_i,
  input  wire logic                       apb_penable_i,
  input  wire logic                       apb_pwrite_i,
  input  wire logic [13:0]                apb_paddr_i,
  input  wire logic [31:0]                apb_pwdata_i,
  output logic      [31:0]                apb_prdata_o,
  // Interrupt bus and processors
  input  wire logic [31:0]                irq_lines_i,
  input  wire itw_pkg::itw_ack_t [3:0]    cpu_ack_i,
  input  wire logic [3:0][1:0]            cpu_owner_i,
  // Watchdog ticks from timer units
  input  wire logic [3:0]                 wd_tick_i,
  // Results
  output logic      [3:0][31:0]           wd_pend_set_o,
  output logic      [3:0][31:0]           boot_addr_o
);
  // ==========================================
  // Declarations
  logic [31:0]      stamp_count_q;
  logic [31:0]      prdata_q;
  logic [3:0][31:0] boot_addr_q;
  logic             wr_access;
  logic             rd_setup;
  logic [1:0]       ctrl_idx;
  logic [11:0]      reg_off;
  logic [3:0]       wd_wr;
  logic [3:0][31:0] wd_rd;
  logic [7:0]       ts_ctl_wr;
  logic [7:0][31:0] ts_ctl_rd;
  logic [7:0][31:0] ts_ast_rd;
  logic [7:0][31:0] ts_ack_rd;
  logic [7:0]       ts_active;
  logic [31:0]      rd_word;

  // ==========================================
  // Address helpers
  function automatic logic word_is(input logic [11:0] off, input logic [11:0] base);
    word_is = (off[11:2] == base[11:2]);
  endfunction

  function automatic logic in_range(input logic [11:0] off, input logic [11:0] lo,
                                    input logic [11:0] hi);
    in_range = (off[11:2] >= lo[11:2]) && (off[11:2] <= hi[11:2]);
  endfunction

  // Flat stamp set index from controller and set bit
  function automatic logic [2:0] set_idx(input logic [1:0] ctrl, input logic set_bit);
    set_idx = {ctrl, set_bit};
  endfunction

  // ==========================================
  // APB decode
  assign ctrl_idx  = apb_paddr_i[13:12];
  assign reg_off   = apb_paddr_i[11:0];
  assign wr_access = apb_psel_i && apb_penable_i && apb_pwrite_i;
  assign rd_setup  = apb_psel_i && !apb_penable_i && !apb_pwrite_i;

  // Watchdog register write strobes per controller
  always_comb begin
    wd_wr = 4'h0;
    if (wr_access && word_is(reg_off, `ITW_OFF_WDCTL)) begin
      wd_wr[ctrl_idx] = 1'b1;
    end
  end

  // Timestamp control write strobes
  always_comb begin
    ts_ctl_wr = 8'h00;
    if (wr_access && in_range(reg_off, `ITW_OFF_TS_BASE, `ITW_OFF_TS_END)
        && reg_off[3:2] == `ITW_TS_CTL) begin
      ts_ctl_wr[set_idx(ctrl_idx, reg_off[4])] = 1'b1;
    end
  end

  // ==========================================
  // Shared timestamp counter
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      stamp_count_q <= 32'h00000000;
    end else if (|ts_active) begin
      stamp_count_q <= stamp_count_q + 32'h00000001;
    end
  end

  // ==========================================
  // Stamp sets, two per controller
  for (genvar g = 0; g < 8; g++) begin : g_set
    itw_stamp_set #(
      .CTRL_ID(2'(g / 2))
    ) u_set (
      .core_clk_i (core_clk_i),
      .reset_i    (reset_i),
      .ctl_wr_i   (ts_ctl_wr[g]),
      .wdata_i    (apb_pwdata_i),
      .irq_lines_i(irq_lines_i),
      .count_i    (stamp_count_q),
      .ack_i      (cpu_ack_i),
      .owner_i    (cpu_owner_i),
      .ctl_rd_o   (ts_ctl_rd[g]),
      .assert_rd_o(ts_ast_rd[g]),
      .ack_rd_o   (ts_ack_rd[g]),
      .active_o   (ts_active[g])
    );
  end

  // ==========================================
  // Watchdog control, one per controller
  for (genvar w = 0; w < `ITW_NUM_CTRL; w++) begin : g_wd
    itw_wd_ctrl u_wd (
      .core_clk_i(core_clk_i),
      .reset_i   (reset_i),
      .wr_i      (wd_wr[w]),
      .wdata_i   (apb_pwdata_i),
      .wd_tick_i (wd_tick_i),
      .ctl_rd_o  (wd_rd[w]),
      .pend_set_o(wd_pend_set_o[w])
    );
  end

  // ==========================================
  // Boot start addresses, shared by all windows
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      for (int p = 0; p < `ITW_NUM_CPU; p++) begin
        boot_addr_q[p] <= `ITW_BOOT_RST;
      end
    end else if (wr_access && in_range(reg_off, `ITW_OFF_BOOT, `ITW_OFF_BOOT_END)) begin
      boot_addr_q[reg_off[3:2]] <= apb_pwdata_i;
    end
  end
  assign boot_addr_o = boot_addr_q;

  // ==========================================
  // Read multiplexer
  always_comb begin
    rd_word = 32'h00000000;
    if (word_is(reg_off, `ITW_OFF_WDCTL)) begin
      rd_word = wd_rd[ctrl_idx];
    end else if (in_range(reg_off, `ITW_OFF_TS_BASE, `ITW_OFF_TS_END)) begin
      unique case (reg_off[3:2])
        `ITW_TS_CNT: rd_word = stamp_count_q;
        `ITW_TS_CTL: rd_word = ts_ctl_rd[set_idx(ctrl_idx, reg_off[4])];
        `ITW_TS_AST: rd_word = ts_ast_rd[set_idx(ctrl_idx, reg_off[4])];
        `ITW_TS_ACK: rd_word = ts_ack_rd[set_idx(ctrl_idx, reg_off[4])];
      endcase
    end else if (in_range(reg_off, `ITW_OFF_BOOT, `ITW_OFF_BOOT_END)) begin
      rd_word = boot_addr_q[reg_off[3:2]];
    end
  end

  // Read data caught in setup phase
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      prdata_q <= 32'h00000000;
    end else if (rd_setup) begin
      prdata_q <= rd_word;
    end
  end
  assign apb_prdata_o = prdata_q;
endmodule

// file: core/itw_wd_ctrl.sv
// Purpose: Watchdog control of one internal controller
// Assumes: Ticks are one-cycle pulses on core_clk_i
// Notes:   Pending set vector is a registered pulse
`timescale 1ns/1ps
`include "itw_consts.svh"
module itw_wd_ctrl (
  input  wire logic        core_clk_i,
  input  wire logic        reset_i,
  input  wire logic        wr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic [3:0]  wd_tick_i,
  output logic      [31:0] ctl_rd_o,
  output logic      [31:0] pend_set_o
);
  logic [3:0]  wd_pending_bit_select_q;
  logic [3:0]  wd_input_enables_q;
  logic [31:0] pend_set_q;
  logic        wd_hit;

  // ==========================================
  // Control register
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      wd_pending_bit_select_q <= 4'h0;
      wd_input_enables_q      <= 4'h0;
    end else if (wr_i) begin
      wd_pending_bit_select_q <= wdata_i[`ITW_WDC_SEL];
      wd_input_enables_q      <= wdata_i[`ITW_WDC_EN];
    end
  end

  // Only enabled inputs count
  assign wd_hit = |(wd_tick_i & wd_input_enables_q);

  // One-cycle pending set pulse
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      pend_set_q <= 32'h00000000;
    end else begin
      pend_set_q <= wd_hit ? (32'h00000001 << wd_pending_bit_select_q) : 32'h00000000;
    end
  end

  // Readback with input count
  always_comb begin
    ctl_rd_o                 = 32'h00000000;
    ctl_rd_o[`ITW_WDC_COUNT] = `ITW_NUM_WD;
    ctl_rd_o[`ITW_WDC_SEL]   = wd_pending_bit_select_q;
    ctl_rd_o[`ITW_WDC_EN]    = wd_input_enables_q;
  end
  assign pend_set_o = pend_set_q;
endmodule

// file: dv/itw_checker.sv
// Purpose: Port-level assertions for itw_top
// Assumes: One clock, reset_i active high
// Notes:   Bound after endmodule
`timescale 1ns/1ps
module itw_checker (
  input  wire logic                    core_clk_i,
  input  wire logic                    reset_i,
  input  wire logic                    apb_psel_i,
  input  wire logic                    apb_penable_i,
  input  wire logic                    apb_pwrite_i,
  input  wire logic [13:0]             apb_paddr_i,
  input  wire logic [31:0]             apb_pwdata_i,
  input  wire logic [31:0]             apb_prdata_o,
  input  wire logic [31:0]             irq_lines_i,
  input  wire itw_pkg::itw_ack_t [3:0] cpu_ack_i,
  input  wire logic [3:0][1:0]         cpu_owner_i,
  input  wire logic [3:0]              wd_tick_i,
  input  wire logic [3:0][31:0]        wd_pend_set_o,
  input  wire logic [3:0][31:0]        boot_addr_o
);
  // ==========================================
  // Helpers
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  logic any_tick, wr_acc, rd_acc, rd_setup;
  assign any_tick = |wd_tick_i;
  assign wr_acc   = apb_psel_i & apb_penable_i & apb_pwrite_i;
  assign rd_acc   = apb_psel_i & apb_penable_i & !apb_pwrite_i;
  assign rd_setup = apb_psel_i & !apb_penable_i & !apb_pwrite_i;
  // ==========================================
  // Assertions
  chk_wd_cause: assert property (wd_pend_set_o != '0 |-> $past(any_tick))
    else $error("pending pulse without a tick");
  chk_wd_onebit: assert property ($onehot0(wd_pend_set_o[1]))
    else $error("more than one pending bit set");
  chk_wd_pulse: assert property (!any_tick |=> wd_pend_set_o == '0)
    else $error("pending pulse outlives its tick");
  chk_boot_reset: assert property ($past(reset_i) |-> boot_addr_o[0] == 32'hC0000000)
    else $error("boot address reset value wrong");
  chk_boot_write: assert property (wr_acc && apb_paddr_i[11:4] == 8'h20 |=>
    boot_addr_o[$past(apb_paddr_i[3:2])] == $past(apb_pwdata_i))
    else $error("boot address write lost");
  chk_boot_hold: assert property (!$stable(boot_addr_o) |-> $past(wr_acc))
    else $error("boot address changed without write");
  chk_rd_hold: assert property (!$stable(apb_prdata_o) |-> $past(rd_setup))
    else $error("read data changed outside a read");
  chk_wd_count: assert property (rd_acc && apb_paddr_i[11:0] == 12'h01C |->
    apb_prdata_o[31:27] == 5'h04)
    else $error("watchdog input count wrong");
  chk_set_count: assert property (rd_acc && apb_paddr_i[11:0] inside {12'h104, 12'h114} |->
    apb_prdata_o[31:27] == 5'h02)
    else $error("stamp set count wrong");
  cov_wd: cover property (wd_pend_set_o[1] != '0);
  cov_boot: cover property (wr_acc && apb_paddr_i[11:4] == 8'h20);
  cov_ack: cover property (cpu_ack_i[0].valid);
endmodule

bind itw_top itw_checker itw_checker_inst (.core_clk_i(core_clk_i), .reset_i(reset_i),
  .apb_psel_i(apb_psel_i), .apb_penable_i(apb_penable_i), .apb_pwrite_i(apb_pwrite_i),
  .apb_paddr_i(apb_paddr_i), .apb_pwdata_i(apb_pwdata_i), .apb_prdata_o(apb_prdata_o),
  .irq_lines_i(irq_lines_i), .cpu_ack_i(cpu_ack_i), .cpu_owner_i(cpu_owner_i),
  .wd_tick_i(wd_tick_i), .wd_pend_set_o(wd_pend_set_o), .boot_addr_o(boot_addr_o));

// file: dv/itw_cpu_model.sv
// Purpose: Processor cores acknowledging interrupts
// Assumes: Acks change 1 ns after a rising edge
// Notes:   Idle line fields keep changing
`timescale 1ns/1ps
module itw_cpu_model (
  input  wire logic                    core_clk_i,
  output itw_pkg::itw_ack_t [3:0]      cpu_ack_o
);
  // ==========================================
  // Idle churn so a stale line never looks valid
  initial cpu_ack_o = '0;
  always @(posedge core_clk_i) begin
    for (int i = 0; i < 4; i++) begin
      if (!cpu_ack_o[i].valid) begin
        cpu_ack_o[i].line <= cpu_ack_o[i].line + 5'h03;
      end
    end
  end
  // One-cycle acknowledge after dly edges
  task automatic ack(input int cpu, input logic [4:0] line, input int dly);
    repeat (dly) @(posedge core_clk_i);
    #1 cpu_ack_o[cpu].line = line;
    cpu_ack_o[cpu].valid = 1'b1;
    @(posedge core_clk_i);
    #1 cpu_ack_o[cpu].valid = 1'b0;
  endtask
endmodule

// file: dv/tb.sv
// Purpose: Self-checking bench for itw_top
// Assumes: 25 MHz clock, inputs change 1 ns after edges
// Notes:   Reads and watchdog pulses checked from queues
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin err_total++; \
  $display("Error at %0t: got %h expected %h", $time, (g), (e)); end end
module tb;
  logic                    core_clk_i, reset_i, apb_psel_i, apb_penable_i, apb_pwrite_i;
  logic [13:0]             apb_paddr_i;
  logic [31:0]             apb_pwdata_i, apb_prdata_o, irq_lines_i, got, v, a0, a1, mv, vv;
  itw_pkg::itw_ack_t [3:0] cpu_ack_i;
  logic [3:0][1:0]         cpu_owner_i;
  logic [3:0]              wd_tick_i, sel;
  logic [3:0][31:0]        wd_pend_set_o, boot_addr_o, wv;
  logic [31:0]             rd_m_q[$], rd_v_q[$];
  logic [3:0][31:0]        wd_q[$];
  logic [4:0]              ln;
  int                      err_total, n_tests, seed, cyc, last, e1, e2;
  // ==========================================
  // Clock, cycle count, design and partner
  initial begin
    core_clk_i = 1'b0;
    forever #20 core_clk_i = ~core_clk_i;
  end
  initial cyc = 0;
  always @(posedge core_clk_i) cyc <= cyc + 1;
  itw_top itw_top_inst (.core_clk_i(core_clk_i), .reset_i(reset_i), .apb_psel_i(apb_psel_i),
    .apb_penable_i(apb_penable_i), .apb_pwrite_i(apb_pwrite_i), .apb_paddr_i(apb_paddr_i),
    .apb_pwdata_i(apb_pwdata_i), .apb_prdata_o(apb_prdata_o), .irq_lines_i(irq_lines_i),
    .cpu_ack_i(cpu_ack_i), .cpu_owner_i(cpu_owner_i), .wd_tick_i(wd_tick_i),
    .wd_pend_set_o(wd_pend_set_o), .boot_addr_o(boot_addr_o));
  itw_cpu_model itw_cpu_model_inst (.core_clk_i(core_clk_i), .cpu_ack_o(cpu_ack_i));
  // ==========================================
  // Bus and stimulus tasks
  task automatic apb(input logic [1:0] c, input logic [11:0] off, input logic wr, input logic [31:0] d);
    @(posedge core_clk_i);
    #1 apb_psel_i = 1'b1;
    apb_pwrite_i = wr;
    apb_paddr_i = {c, off};
    apb_pwdata_i = d;
    @(posedge core_clk_i);
    #1 apb_penable_i = 1'b1;
    @(posedge core_clk_i);
    got = apb_prdata_o;
    #1 apb_psel_i = 1'b0;
    apb_penable_i = 1'b0;
  endtask
  task automatic rd(input logic [1:0] c, input logic [11:0] off, input logic [31:0] e,
                    input logic [31:0] m = 32'hFFFFFFFF);
    rd_m_q.push_back(m);
    rd_v_q.push_back(e);
    apb(c, off, 1'b0, $random(seed));
  endtask
  // Selected line high for n cycles; last holds final sample edge
  task automatic pulse(input int n);
    @(posedge core_clk_i);
    #1 irq_lines_i[ln] = 1'b1;
    repeat (n) @(posedge core_clk_i);
    #1 last = cyc;
    irq_lines_i = $random(seed) & ~(32'h1 << ln);
  endtask
  task automatic conclude();
    if (err_total == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // ==========================================
  // Monitor: oldest note against each result
  always @(posedge core_clk_i) begin
    if (apb_psel_i && apb_penable_i && !apb_pwrite_i) begin
      mv = rd_m_q.pop_front();
      vv = rd_v_q.pop_front();
      `CHK(apb_prdata_o & mv, vv & mv)
    end
    if (wd_pend_set_o !== '0) begin
      wv = wd_q.pop_front();
      `CHK(wd_pend_set_o, wv)
    end
  end
  // Watchdog: run needs well under 10000 cycles
  initial begin
    #400000;
    err_total++;
    conclude();
  end
  // ==========================================
  // Main sequence
  initial begin
    seed = 94;
    err_total = 0;
    n_tests = 0;
    {reset_i, apb_psel_i, apb_penable_i, apb_pwrite_i} = 4'h8;
    {apb_paddr_i, apb_pwdata_i, irq_lines_i, wd_tick_i} = '0;
    cpu_owner_i = {2'h1, 2'h0, 2'h0, 2'h0};
    repeat (20) @(posedge core_clk_i);
    #1 reset_i = 1'b0;
    // Boot addresses from every window
    for (int i = 0; i < 4; i++) rd(i[1:0], 12'h200 + 12'(4 * i), 32'hC0000000);
    v = $random(seed) & 32'hFFFFF000;
    wr_boot: apb(2'h2, 12'h204, 1'b1, v);
    `CHK(boot_addr_o[1], v)
    rd(2'h0, 12'h204, v);
    rd(2'h3, 12'h018, 32'h0);
    rd(2'h0, 12'h104, 32'h10000000);
    // Watchdog enables and pending select
    sel = 4'($random(seed));
    apb(2'h1, 12'h01C, 1'b1, {12'h0, sel, 16'hFFF5});
    rd(2'h1, 12'h01C, {5'h04, 7'h0, sel, 16'h0005});
    rd(2'h3, 12'h01C, 32'h20000000);
    for (int n = 0; n < 5; n++) begin
      @(posedge core_clk_i);
      #1 wd_tick_i = (n == 4) ? 4'hF : 4'h1 << n;
      if (n == 4 || n[0] == 1'b0) wd_q.push_back({32'h0, 32'h0, 32'h1 << sel, 32'h0});
      @(posedge core_clk_i);
      #1 wd_tick_i = 4'h0;
    end
    // Keep-first stamping
    ln = 5'($random(seed)) | 5'h01;
    apb(2'h0, 12'h104, 1'b1, 32'h20 | ln);
    pulse(1);
    e1 = last;
    rd(2'h0, 12'h108, 32'h0, 32'h0);
    a0 = got;
    rd(2'h0, 12'h104, 32'h14000020 | ln);
    itw_cpu_model_inst.ack(3, ln, 2);
    rd(2'h0, 12'h104, 32'h14000020 | ln);
    itw_cpu_model_inst.ack(0, ln, 3);
    e2 = cyc;
    rd(2'h0, 12'h10C, a0 + e2 - e1);
    rd(2'h0, 12'h104, 32'h16000020 | ln);
    pulse(1);
    itw_cpu_model_inst.ack(0, ln, 1);
    rd(2'h0, 12'h108, a0);
    rd(2'h0, 12'h10C, a0 + e2 - e1);
    apb(2'h0, 12'h104, 1'b1, 32'h06000020 | ln);
    rd(2'h0, 12'h104, 32'h10000020 | ln);
    pulse(1);
    rd(2'h0, 12'h108, a0 + last - e1);
    // Continuous stamping
    apb(2'h0, 12'h104, 1'b1, 32'h06000000 | ln);
    itw_cpu_model_inst.ack(0, ln, 1);
    e2 = cyc;
    rd(2'h0, 12'h10C, a0 + e2 - e1);
    pulse(3);
    a1 = a0 + last - e1;
    rd(2'h0, 12'h108, a1);
    rd(2'h0, 12'h104, 32'h14000000 | ln);
    // Zero selection halts the shared counter
    apb(2'h0, 12'h104, 1'b1, 32'h06000000);
    rd(2'h2, 12'h110, 32'h0, 32'h0);
    v = got;
    pulse(1);
    rd(2'h0, 12'h100, v);
    rd(2'h0, 12'h108, a1);
    `CHK(wd_q.size(), 0)
    conclude();
  end
endmodule
